//--- hw/rtn_rot_map.vh
// Register offsets, field positions and timing counts for the return and rotate executor
`ifndef RTN_ROT_MAP_VH
`define RTN_ROT_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INSTR_POINTER 8'h08
`define OFS_STACK_TOP 8'h0c
`define OFS_INDEX_FIRST 8'h10
`define OFS_INDEX_SECOND 8'h14
`define OFS_AF 8'h18
`define OFS_BC 8'h1c
`define OFS_DE 8'h20
`define OFS_HL 8'h24
`define OFS_TIMING 8'h28

// ----------------------------------------
// Control and status bits
// ----------------------------------------
`define CTRL_RUN 0
`define CTRL_STEP 1
`define CTRL_NMI 2
`define ST_BUSY 0
`define ST_IRQ_MAIN 1
`define ST_IRQ_SAVED 2
`define ST_ILLEGAL 3
`define ST_NMI_PEND 4

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define FL_S 7
`define FL_Z 6
`define FL_H 4
`define FL_PV 2
`define FL_N 1
`define FL_C 0

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_SUB_EXIT 8'hc9
`define OP_ACC_ROT 8'h17
`define OP_PFX_BIT 8'hcb
`define OP_PFX_EXT 8'hed
`define OP_PFX_IDX1 8'hdd
`define OP_PFX_IDX2 8'hfd
`define OP_ISR_EXIT 8'h4d
`define OP_URGENT_EXIT 8'h45
`define OP_ROT_MEM 8'h16
`define ROT_VIA_CARRY_HI 5'h02
`define RST_NMI_ADDR 16'h0066

// ----------------------------------------
// T-state lengths of machine cycles
// ----------------------------------------
`define T_FETCH 4'h4
`define T_MEM 4'h3
`define T_OPRD 4'h4
`define T_IDXOP 4'h5
`define T_NMI 4'h5
`define T_COND_EXT 4'h1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_STACK_TOP 16'hffff
`define RST_WORD 16'h0000

`endif

//--- hw/rtn_rot_exec.v
// Executor for subroutine and interrupt exits and rotates through carry
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
// Function
// - Subroutine exit 10 T-states, flags kept
// - Taken exit pops low byte, then high
// - Next opcode fetched from restored pointer
// - False condition leaves stack untouched
// - Condition field selects flag test
// - Taken conditional exit 11 T-states
// - False conditional exit 5 T-states
// - Exits leave condition flags unchanged
// - Interrupt exit pops like subroutine exit
// - Interrupt exit keeps enable latches
// - Interrupt exits take 14 T-states
// - Urgent exit pops pointer, low first
// - Urgent exit copies saved latch to main
// - Urgent request pushes pointer, jumps 0066
// - Rotate left via carry bit movement
// - Register field encodes target register
// - Operand forms on prefixed page, byte 16
// - Rotate timing 8, 15, 23 T-states
// - Prefixed rotate sets S Z PV, clears H N
// - Accumulator rotate uses same movement
// - Accumulator rotate 4 T-states, partial flags
// - Indexed address adds signed displacement
`include "rtn_rot_map.vh"

module rtn_rot_exec
(
	// Clock and reset
	input wire i_clock,
	input wire i_resetn,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [7:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// Memory port
	output reg [15:0] o_mem_addr,
	output reg o_mem_rd,
	output reg o_mem_wr,
	output reg [7:0] o_mem_wdata,
	input wire [7:0] i_mem_rdata,
	// Peripheral chain
	output reg o_isr_exit,
	output reg o_instr_done
);

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	localparam S_IDLE = 4'h0;
	localparam S_OP1 = 4'h1;
	localparam S_CND = 4'h2;
	localparam S_OP2 = 4'h3;
	localparam S_DISP = 4'h4;
	localparam S_OP3 = 4'h5;
	localparam S_MRD = 4'h6;
	localparam S_MWR = 4'h7;
	localparam S_POPL = 4'h8;
	localparam S_POPH = 4'h9;
	localparam S_NMI0 = 4'ha;
	localparam S_PUSHH = 4'hb;
	localparam S_PUSHL = 4'hc;

	localparam X_NONE = 2'h0;
	localparam X_ISR = 2'h1;
	localparam X_URGENT = 2'h2;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [3:0] state;
	reg [3:0] tcnt;
	reg [15:0] instr_pointer;
	reg [15:0] stack_top_pointer;
	reg [15:0] index_reg_first;
	reg [15:0] index_reg_second;
	reg [7:0] gpr [0:7];
	reg irq_enable_latch_main;
	reg irq_enable_latch_saved;
	reg [1:0] pfx;
	reg [1:0] exit_kind;
	reg [15:0] ea;
	reg run;
	reg step;
	reg nmi_pend;
	reg illegal;
	reg [7:0] t_acc;
	reg [3:0] m_acc;
	reg [7:0] last_t;
	reg [3:0] last_m;
	integer k;

	wire [7:0] flags = gpr[6];
	wire [15:0] hl = {gpr[4], gpr[5]};
	wire reg_hit = (i_paddr[1:0] == 2'h0) && (i_paddr <= `OFS_TIMING);
	wire apb_access = i_psel && i_penable;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [8:0] rot_via_carry;
		input [7:0] v;
		input c;
		begin
			rot_via_carry = {v[7], v[6:0], c};
		end
	endfunction

	function [7:0] rot_flags;
		input [7:0] old;
		input [8:0] r;
		begin
			rot_flags = {r[7], (r[7:0] == 8'h00), old[5], 1'b0, old[3], ~^r[7:0], 1'b0,
				r[8]};
		end
	endfunction

	function cond_true;
		input [2:0] cc;
		input [7:0] f;
		reg bitv;
		begin
			case (cc[2:1])
				2'h0: bitv = f[`FL_Z];
				2'h1: bitv = f[`FL_C];
				2'h2: bitv = f[`FL_PV];
				default: bitv = f[`FL_S];
			endcase
			cond_true = cc[0] ? bitv : ~bitv;
		end
	endfunction

	function [15:0] rd_word;
		input [7:0] a;
		begin
			case (a)
				`OFS_CTRL: rd_word = {13'h0000, nmi_pend, step, run};
				`OFS_STATUS: rd_word = {11'h000, nmi_pend, illegal, irq_enable_latch_saved,
					irq_enable_latch_main, (state != S_IDLE)};
				`OFS_INSTR_POINTER: rd_word = instr_pointer;
				`OFS_STACK_TOP: rd_word = stack_top_pointer;
				`OFS_INDEX_FIRST: rd_word = index_reg_first;
				`OFS_INDEX_SECOND: rd_word = index_reg_second;
				`OFS_AF: rd_word = {gpr[7], gpr[6]};
				`OFS_BC: rd_word = {gpr[0], gpr[1]};
				`OFS_DE: rd_word = {gpr[2], gpr[3]};
				`OFS_HL: rd_word = hl;
				`OFS_TIMING: rd_word = {4'h0, last_m, last_t};
				default: rd_word = 16'h0000;
			endcase
		end
	endfunction

	// New request wins over an accept in the same cycle
	wire nmi_set = apb_access && o_pready && i_pwrite && (i_paddr == `OFS_CTRL) &&
		i_pwdata[`CTRL_NMI];
	wire [8:0] reg_rot = rot_via_carry(gpr[i_mem_rdata[2:0]], flags[`FL_C]);
	wire [8:0] mem_rot = rot_via_carry(i_mem_rdata, flags[`FL_C]);

	// ----------------------------------------
	// Machine cycle launch
	// ----------------------------------------
	task begin_cycle;
		input [3:0] st;
		input [3:0] len;
		input [15:0] addr;
		input rd;
		input wr;
		input [7:0] wd;
		input newm;
		begin
			state <= st;
			tcnt <= len;
			o_mem_addr <= addr;
			o_mem_rd <= rd;
			o_mem_wr <= wr;
			o_mem_wdata <= wd;
			if (newm)
				m_acc <= m_acc + 4'h1;
		end
	endtask

	task finish;
		begin
			state <= S_IDLE;
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_instr_done <= 1'b1;
			last_t <= t_acc + 8'h01;
			last_m <= m_acc;
		end
	endtask

	// ----------------------------------------
	// Bus slave and sequencer
	// ----------------------------------------
	always @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_prdata <= 32'h00000000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_mem_addr <= `RST_WORD;
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_mem_wdata <= 8'h00;
			o_isr_exit <= 1'b0;
			o_instr_done <= 1'b0;
			state <= S_IDLE;
			tcnt <= 4'h0;
			instr_pointer <= `RST_WORD;
			stack_top_pointer <= `RST_STACK_TOP;
			index_reg_first <= `RST_WORD;
			index_reg_second <= `RST_WORD;
			for (k = 0; k < 8; k = k + 1)
				gpr[k] <= 8'h00;
			irq_enable_latch_main <= 1'b0;
			irq_enable_latch_saved <= 1'b0;
			pfx <= 2'h0;
			exit_kind <= X_NONE;
			ea <= `RST_WORD;
			run <= 1'b0;
			step <= 1'b0;
			nmi_pend <= 1'b0;
			illegal <= 1'b0;
			t_acc <= 8'h00;
			m_acc <= 4'h0;
			last_t <= 8'h00;
			last_m <= 4'h0;
		end
		else
		begin
			o_isr_exit <= 1'b0;
			o_instr_done <= 1'b0;
			// One wait state keeps read data coming from a flop
			if (apb_access && !o_pready)
			begin
				o_pready <= 1'b1;
				o_pslverr <= !reg_hit;
				o_prdata <= {16'h0000, rd_word(i_paddr)};
			end
			else
			begin
				o_pready <= 1'b0;
				o_pslverr <= 1'b0;
			end
			// Writes land on the completing edge; machine state only while idle
			if (apb_access && o_pready && i_pwrite && reg_hit)
			begin
				case (i_paddr)
					`OFS_CTRL:
					begin
						run <= i_pwdata[`CTRL_RUN];
						step <= i_pwdata[`CTRL_STEP];
						if (i_pwdata[`CTRL_NMI])
							nmi_pend <= 1'b1;
					end
					`OFS_STATUS:
						if (state == S_IDLE)
						begin
							irq_enable_latch_main <= i_pwdata[`ST_IRQ_MAIN];
							irq_enable_latch_saved <= i_pwdata[`ST_IRQ_SAVED];
							illegal <= 1'b0;
						end
					default:
						if (state == S_IDLE)
							case (i_paddr)
								`OFS_INSTR_POINTER: instr_pointer <= i_pwdata[15:0];
								`OFS_STACK_TOP: stack_top_pointer <= i_pwdata[15:0];
								`OFS_INDEX_FIRST: index_reg_first <= i_pwdata[15:0];
								`OFS_INDEX_SECOND: index_reg_second <= i_pwdata[15:0];
								`OFS_AF: {gpr[7], gpr[6]} <= i_pwdata[15:0];
								`OFS_BC: {gpr[0], gpr[1]} <= i_pwdata[15:0];
								`OFS_DE: {gpr[2], gpr[3]} <= i_pwdata[15:0];
								`OFS_HL: {gpr[4], gpr[5]} <= i_pwdata[15:0];
								default: illegal <= illegal;
							endcase
				endcase
			end

			if (state != S_IDLE)
			begin
				t_acc <= t_acc + 8'h01;
				if (tcnt != 4'h1)
					tcnt <= tcnt - 4'h1;
			end

			case (state)
				S_IDLE:
				begin
					t_acc <= 8'h00;
					m_acc <= 4'h1;
					pfx <= 2'h0;
					exit_kind <= X_NONE;
					if (nmi_pend)
					begin
						if (!nmi_set)
							nmi_pend <= 1'b0;
						begin_cycle(S_NMI0, `T_NMI, instr_pointer, 1'b0, 1'b0, 8'h00, 1'b0);
					end
					else if (run || step)
					begin
						step <= 1'b0;
						begin_cycle(S_OP1, `T_FETCH, instr_pointer, 1'b1, 1'b0, 8'h00, 1'b0);
					end
				end
				S_OP1:
					if (tcnt == 4'h1)
					begin
						instr_pointer <= instr_pointer + 16'h0001;
						if (i_mem_rdata == `OP_SUB_EXIT)
							begin_cycle(S_POPL, `T_MEM, stack_top_pointer, 1'b1, 1'b0, 8'h00,
								1'b1);
						else if (i_mem_rdata[7:6] == 2'h3 && i_mem_rdata[2:0] == 3'h0)
						begin
							ea <= {13'h0000, i_mem_rdata[5:3]};
							begin_cycle(S_CND, `T_COND_EXT, stack_top_pointer, 1'b0, 1'b0,
								8'h00, 1'b0);
						end
						else if (i_mem_rdata == `OP_ACC_ROT)
						begin
							{gpr[6][`FL_C], gpr[7]} <= rot_via_carry(gpr[7], flags[`FL_C]);
							gpr[6][`FL_H] <= 1'b0;
							gpr[6][`FL_N] <= 1'b0;
							finish;
						end
						else if (i_mem_rdata == `OP_PFX_BIT || i_mem_rdata == `OP_PFX_EXT ||
							i_mem_rdata == `OP_PFX_IDX1 || i_mem_rdata == `OP_PFX_IDX2)
						begin
							pfx <= (i_mem_rdata == `OP_PFX_IDX1) ? 2'h1 :
								(i_mem_rdata == `OP_PFX_IDX2) ? 2'h2 :
								(i_mem_rdata == `OP_PFX_EXT) ? 2'h3 : 2'h0;
							begin_cycle(S_OP2, `T_FETCH, instr_pointer + 16'h0001, 1'b1, 1'b0,
								8'h00, 1'b1);
						end
						else
						begin
							illegal <= 1'b1;
							finish;
						end
					end
				S_CND:
					if (cond_true(ea[2:0], flags))
						begin_cycle(S_POPL, `T_MEM, stack_top_pointer, 1'b1, 1'b0, 8'h00,
							1'b1);
					else
						finish;
				S_OP2:
					if (tcnt == 4'h1)
					begin
						instr_pointer <= instr_pointer + 16'h0001;
						if (pfx == 2'h3)
						begin
							if (i_mem_rdata == `OP_ISR_EXIT || i_mem_rdata == `OP_URGENT_EXIT)
							begin
								exit_kind <= (i_mem_rdata == `OP_ISR_EXIT) ? X_ISR : X_URGENT;
								begin_cycle(S_POPL, `T_MEM, stack_top_pointer, 1'b1, 1'b0,
									8'h00, 1'b1);
							end
							else
							begin
								illegal <= 1'b1;
								finish;
							end
						end
						else if (pfx != 2'h0)
						begin
							if (i_mem_rdata == `OP_PFX_BIT)
								begin_cycle(S_DISP, `T_MEM, instr_pointer + 16'h0001, 1'b1,
									1'b0, 8'h00, 1'b1);
							else
							begin
								illegal <= 1'b1;
								finish;
							end
						end
						else if (i_mem_rdata[7:3] != `ROT_VIA_CARRY_HI)
						begin
							illegal <= 1'b1;
							finish;
						end
						else if (i_mem_rdata[2:0] == 3'h6)
						begin
							ea <= hl;
							begin_cycle(S_MRD, `T_OPRD, hl, 1'b1, 1'b0, 8'h00, 1'b1);
						end
						else
						begin
							gpr[i_mem_rdata[2:0]] <= reg_rot[7:0];
							gpr[6] <= rot_flags(flags, reg_rot);
							finish;
						end
					end
				S_DISP:
					if (tcnt == 4'h1)
					begin
						instr_pointer <= instr_pointer + 16'h0001;
						ea <= ((pfx == 2'h1) ? index_reg_first : index_reg_second) +
							{{8{i_mem_rdata[7]}}, i_mem_rdata};
						begin_cycle(S_OP3, `T_IDXOP, instr_pointer + 16'h0001, 1'b1, 1'b0,
							8'h00, 1'b1);
					end
				S_OP3:
					if (tcnt == 4'h1)
					begin
						instr_pointer <= instr_pointer + 16'h0001;
						if (i_mem_rdata == `OP_ROT_MEM)
							begin_cycle(S_MRD, `T_OPRD, ea, 1'b1, 1'b0, 8'h00, 1'b1);
						else
						begin
							illegal <= 1'b1;
							finish;
						end
					end
				S_MRD:
					if (tcnt == 4'h1)
					begin
						gpr[6] <= rot_flags(flags, mem_rot);
						begin_cycle(S_MWR, `T_MEM, ea, 1'b0, 1'b1, mem_rot[7:0], 1'b1);
					end
				S_MWR:
					if (tcnt == 4'h1)
						finish;
				S_POPL:
					if (tcnt == 4'h1)
					begin
						instr_pointer[7:0] <= i_mem_rdata;
						stack_top_pointer <= stack_top_pointer + 16'h0001;
						begin_cycle(S_POPH, `T_MEM, stack_top_pointer + 16'h0001, 1'b1, 1'b0,
							8'h00, 1'b1);
					end
				S_POPH:
					if (tcnt == 4'h1)
					begin
						instr_pointer[15:8] <= i_mem_rdata;
						stack_top_pointer <= stack_top_pointer + 16'h0001;
						if (exit_kind == X_URGENT)
							irq_enable_latch_main <= irq_enable_latch_saved;
						if (exit_kind == X_ISR)
							o_isr_exit <= 1'b1;
						finish;
					end
				S_NMI0:
					if (tcnt == 4'h1)
					begin
						stack_top_pointer <= stack_top_pointer - 16'h0001;
						begin_cycle(S_PUSHH, `T_MEM, stack_top_pointer - 16'h0001, 1'b0, 1'b1,
							instr_pointer[15:8], 1'b1);
					end
				S_PUSHH:
					if (tcnt == 4'h1)
					begin
						stack_top_pointer <= stack_top_pointer - 16'h0001;
						begin_cycle(S_PUSHL, `T_MEM, stack_top_pointer - 16'h0001, 1'b0, 1'b1,
							instr_pointer[7:0], 1'b1);
					end
				S_PUSHL:
					if (tcnt == 4'h1)
					begin
						instr_pointer <= `RST_NMI_ADDR;
						irq_enable_latch_main <= 1'b0;
						finish;
					end
				default:
					state <= S_IDLE;
			endcase
		end
	end

endmodule

//--- dv/mem_model.sv
// Stack memory and one daisy-chained peripheral facing the executor
`timescale 1ns/1ps
module mem_model
(
	// Clock
	input wire logic i_clock,
	// Memory port
	input wire logic [15:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	// Chain
	input wire logic i_ack,
	input wire logic i_isr_exit,
	output logic o_chain_en
);
	logic [7:0] mem [0:65535];
	initial o_chain_en = 1'b1;
	// Unselected: inverted byte, so a stale read never passes
	assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
	always @(posedge i_clock)
	begin
		if (i_wr)
			mem[i_addr] <= i_wdata;
		if (i_ack)
			o_chain_en <= 1'b0;
		else if (i_isr_exit)
			o_chain_en <= 1'b1;
	end
endmodule

//--- dv/rtn_rot_checker.sv
// Port assertions for the return and rotate executor
`timescale 1ns/1ps
`include "rtn_rot_map.vh"
module rtn_rot_checker
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// Watched ports
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [15:0] o_mem_addr,
	input wire logic o_mem_rd,
	input wire logic o_mem_wr,
	input wire logic [7:0] o_mem_wdata,
	input wire logic o_isr_exit,
	input wire logic o_instr_done
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	property p_ready_next; i_psel && i_penable && !o_pready |=> o_pready; endproperty
	a_ready_next: assert property (p_ready_next) else $error("pready late");
	property p_ready_pulse; o_pready |=> !o_pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
	property p_err_addr; o_pslverr |-> i_paddr > `OFS_TIMING || i_paddr[1:0] != 2'h0; endproperty
	a_err_addr: assert property (p_err_addr) else $error("pslverr on mapped");
	property p_err_ready; o_pslverr |-> o_pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_rdata_hold; !(i_psel && i_penable) |=> $stable(o_prdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved");
	property p_done_pulse; o_instr_done |=> !o_instr_done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done long");
	property p_no_both; !(o_mem_rd && o_mem_wr); endproperty
	a_no_both: assert property (p_no_both) else $error("read and write");
	property p_cycle_min; $rose(o_mem_rd || o_mem_wr) |-> (o_mem_rd || o_mem_wr) [*3]; endproperty
	a_cycle_min: assert property (p_cycle_min) else $error("short cycle");
	property p_push_down;
		o_mem_wr && $past(o_mem_wr) && o_mem_addr != $past(o_mem_addr)
			|-> o_mem_addr == $past(o_mem_addr) - 16'h1;
	endproperty
	a_push_down: assert property (p_push_down) else $error("push order");
	property p_wdata_hold;
		o_mem_wr && $past(o_mem_wr) && o_mem_addr == $past(o_mem_addr)
			|-> o_mem_wdata == $past(o_mem_wdata);
	endproperty
	a_wdata_hold: assert property (p_wdata_hold) else $error("wdata moved");
	property p_isr_pulse; o_isr_exit |=> !o_isr_exit; endproperty
	a_isr_pulse: assert property (p_isr_pulse) else $error("exit pulse long");
	c_isr: cover property (o_isr_exit);
	c_push: cover property (o_mem_wr);
	c_err: cover property (o_pslverr);
endmodule
bind rtn_rot_exec rtn_rot_checker u_chk (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel),
	.i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
	.o_mem_wdata(o_mem_wdata), .o_isr_exit(o_isr_exit), .o_instr_done(o_instr_done));

//--- dv/tb_top.sv
// Self-checking bench for the return and rotate executor
`timescale 1ns/1ps
`include "rtn_rot_map.vh"
module tb_top;
	logic i_clock = 0, i_resetn = 0, psel = 0, penable = 0, pwrite = 0, ack = 0;
	logic [7:0] paddr = 0, wdat, rdat;
	logic [31:0] pwdata = 0, prdata, rdv;
	logic pready, pslverr, erv, mem_rd, mem_wr, isr_exit, done, chain_en;
	logic [15:0] mem_addr;
	int miscompares = 0, comparisons = 0;
	always #25 i_clock = ~i_clock;
	rtn_rot_exec DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_mem_addr(mem_addr),
		.o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_wdata(wdat), .i_mem_rdata(rdat),
		.o_isr_exit(isr_exit), .o_instr_done(done));
	mem_model MEM (.i_clock(i_clock), .i_addr(mem_addr), .i_rd(mem_rd), .i_wr(mem_wr),
		.i_wdata(wdat), .o_rdata(rdat), .i_ack(ack), .i_isr_exit(isr_exit),
		.o_chain_en(chain_en));
	task stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		do
		begin
			@(posedge i_clock);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			miscompares++;
			stop_test();
		end
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, rdv, e);
	endtask
	task ld(input logic [15:0] pc, input logic [15:0] sp, input logic [15:0] af);
		apb(1'b1, `OFS_INSTR_POINTER, {16'h0, pc});
		apb(1'b1, `OFS_STACK_TOP, {16'h0, sp});
		apb(1'b1, `OFS_AF, {16'h0, af});
	endtask
	// Completion is taken from the done pulse, bounded
	task step(input logic [31:0] c);
		int n;
		n = 0;
		apb(1'b1, `OFS_CTRL, c);
		while (done !== 1'b1 && n < 60)
		begin
			@(posedge i_clock);
			n++;
		end
		if (done !== 1'b1)
		begin
			miscompares++;
			stop_test();
		end
	endtask
	task post(input logic [15:0] pc, input logic [15:0] sp, input logic [15:0] af,
		input logic [11:0] tm);
		rd(`OFS_INSTR_POINTER, {16'h0, pc}, "pointer");
		rd(`OFS_STACK_TOP, {16'h0, sp}, "stack");
		rd(`OFS_AF, {16'h0, af}, "af");
		rd(`OFS_TIMING, {20'h0, tm}, "timing");
	endtask
	initial
	begin
		int op;
		logic [15:0] v;
		logic [15:0] t;
		repeat (16) @(posedge i_clock);
		i_resetn <= 1'b1;
		rd(`OFS_STATUS, 32'h0, "status");
		rd(`OFS_STACK_TOP, 32'hffff, "stack");
		apb(1'b0, 8'h3c, 32'h0);
		chk("slverr", {31'h0, erv}, 32'h1);
		chk("unmapped", rdv, 32'h0);
		MEM.mem[16'h2000] = 8'hb5;
		MEM.mem[16'h2001] = 8'h18;
		MEM.mem[16'h0100] = `OP_SUB_EXIT;
		ld(16'h0100, 16'h2000, 16'h12d7);
		step(32'h2);
		post(16'h18b5, 16'h2002, 16'h12d7, 12'h30a);
		for (op = 0; op < 16; op++)
		begin
			MEM.mem[16'h0100] = {2'b11, op[2:0], 3'b000};
			v = {8'h00, {8{op[3]}}};
			ld(16'h0100, 16'h2000, v);
			step(32'h2);
			if (op[0] == op[3])
				post(16'h18b5, 16'h2002, v, 12'h30b);
			else
				post(16'h0101, 16'h2000, v, 12'h105);
		end
		MEM.mem[16'h0100] = `OP_PFX_EXT;
		MEM.mem[16'h0101] = `OP_ISR_EXIT;
		ld(16'h0100, 16'h2000, 16'h12d7);
		apb(1'b1, `OFS_STATUS, 32'h6);
		ack <= 1'b1;
		@(posedge i_clock);
		ack <= 1'b0;
		@(posedge i_clock);
		chk("chain", {31'h0, chain_en}, 32'h0);
		step(32'h2);
		post(16'h18b5, 16'h2002, 16'h12d7, 12'h40e);
		chk("chain", {31'h0, chain_en}, 32'h1);
		rd(`OFS_STATUS, 32'h6, "status");
		ld(16'h1a45, 16'h1000, 16'h12d7);
		step(32'h4);
		rd(`OFS_STATUS, 32'h4, "status");
		rd(`OFS_INSTR_POINTER, 32'h0066, "pointer");
		rd(`OFS_STACK_TOP, 32'h0ffe, "stack");
		chk("push high", {24'h0, MEM.mem[16'h0fff]}, 32'h1a);
		chk("push low", {24'h0, MEM.mem[16'h0ffe]}, 32'h45);
		MEM.mem[16'h0066] = `OP_PFX_EXT;
		MEM.mem[16'h0067] = `OP_URGENT_EXIT;
		step(32'h2);
		post(16'h1a45, 16'h1000, 16'h12d7, 12'h40e);
		rd(`OFS_STATUS, 32'h6, "status");
		MEM.mem[16'h0100] = `OP_ACC_ROT;
		ld(16'h0100, 16'h2000, 16'h76d7);
		step(32'h2);
		post(16'h0101, 16'h2000, 16'hedc4, 12'h104);
		MEM.mem[16'h0100] = `OP_PFX_BIT;
		for (op = 0; op < 8; op++)
		begin
			if (op == 6)
				continue;
			MEM.mem[16'h0101] = 8'h10 | op[7:0];
			apb(1'b1, `OFS_BC, 32'h8888);
			apb(1'b1, `OFS_DE, 32'h8888);
			apb(1'b1, `OFS_HL, 32'h8888);
			ld(16'h0100, 16'h2000, 16'h8800);
			step(32'h2);
			if (op == 7)
				post(16'h0102, 16'h2000, 16'h1001, 12'h208);
			else
			begin
				v = op[0] ? 16'h8810 : 16'h1088;
				rd(`OFS_BC + 8'(4 * (op / 2)), {16'h0, v}, "pair");
				post(16'h0102, 16'h2000, 16'h8801, 12'h208);
			end
		end
		MEM.mem[16'h0101] = `OP_ROT_MEM;
		MEM.mem[16'h2828] = 8'h80;
		apb(1'b1, `OFS_HL, 32'h2828);
		ld(16'h0100, 16'h2000, 16'h8800);
		step(32'h2);
		chk("mem", {24'h0, MEM.mem[16'h2828]}, 32'h0);
		post(16'h0102, 16'h2000, 16'h8845, 12'h40f);
		for (op = 0; op < 2; op++)
		begin
			t = op ? 16'h1002 : 16'h0ffe;
			MEM.mem[16'h0100] = op ? `OP_PFX_IDX2 : `OP_PFX_IDX1;
			MEM.mem[16'h0101] = `OP_PFX_BIT;
			MEM.mem[16'h0102] = op ? 8'h02 : 8'hfe;
			MEM.mem[16'h0103] = `OP_ROT_MEM;
			MEM.mem[t] = 8'h01;
			apb(1'b1, op ? `OFS_INDEX_SECOND : `OFS_INDEX_FIRST, 32'h1000);
			ld(16'h0100, 16'h2000, 16'h8801);
			step(32'h2);
			chk("indexed", {24'h0, MEM.mem[t]}, 32'h03);
			post(16'h0104, 16'h2000, 16'h8804, 12'h617);
		end
		stop_test();
	end
endmodule
